// [shared/cbw_cfg.svh]
// constants for the bus bias and wake control block
`ifndef CBW_CFG_SVH
`define CBW_CFG_SVH
`define CBW_CLK_MHZ        40
`define CBW_TICK_US        1
`define CBW_TICK_CYCLES    (`CBW_CLK_MHZ * `CBW_TICK_US)
`define CBW_TICK_W         6
`define CBW_SILENCE_US_DEF 900
`define CBW_SIL_W          16
`define CBW_SYNC_W         9
`define CBW_S_WAKE         0
`define CBW_S_TXD          1
`define CBW_S_BUSDOM       2
`define CBW_S_BATT_LOW     3
`define CBW_S_BATT_OK      4
`define CBW_S_CORE_LOW     5
`define CBW_S_CORE_OK      6
`define CBW_S_IO_LOW       7
`define CBW_S_IO_OK        8
`define CBW_SYNC_RST       9'h000
`define CBW_RXD_IDLE       1'b1
`define CBW_BUF_DEPTH      2
`define CBW_CNT_W          2
`define CBW_SETTLE_W       2
`define CBW_SETTLE_DONE    2'h3
`endif

// [shared/cbw_pkg.sv]
// types of the bus bias and wake control block
package cbw_pkg;
	typedef enum logic [1:0] {
		BIAS_OFF,
		BIAS_AUTO_INACTIVE,
		BIAS_AUTO_ACTIVE,
		BIAS_ACTIVE
	} cbw_bias_e;
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_SILENT,
		MODE_STANDBY,
		MODE_GOTOSLEEP,
		MODE_SLEEP
	} cbw_mode_e;
	typedef struct packed {
		logic remote_bus_wake_pattern;
		logic local_pin_wake_event;
	} cbw_wake_s;
endpackage

// [shared/cbw_stream_if.sv]
// valid/ready carrier for wake records
`timescale 1ns/1ps
interface cbw_stream_if;
	logic              valid;
	logic              ready;
	cbw_pkg::cbw_wake_s data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// [src/cbw_buf2.sv]
// two-entry wake record buffer
`timescale 1ns/1ps
`include "cbw_cfg.svh"
module cbw_buf2 (
	// clock and reset
	input  logic      clock_i,
	input  logic      reset_i,
	// filling side
	cbw_stream_if.snk in_if,
	// draining side
	cbw_stream_if.src out_if
);
	cbw_pkg::cbw_wake_s          mem_q [`CBW_BUF_DEPTH];
	logic                        wr_ptr_q;
	logic                        rd_ptr_q;
	logic [`CBW_CNT_W-1:0]       cnt_q;
	logic                        push;
	logic                        pop;

	assign in_if.ready  = (cnt_q != `CBW_CNT_W'(`CBW_BUF_DEPTH));
	assign out_if.valid = (cnt_q != `CBW_CNT_W'(0));
	assign out_if.data  = mem_q[rd_ptr_q];
	assign push = in_if.valid & in_if.ready;
	assign pop  = out_if.valid & out_if.ready;

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_if.data;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			cnt_q    <= `CBW_CNT_W'(0);
		end else begin
			if (push) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + `CBW_CNT_W'(1);
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - `CBW_CNT_W'(1);
			end
		end
	end

	property p_buf_no_overrun;
		@(posedge clock_i) disable iff (reset_i)
		cnt_q == `CBW_CNT_W'(`CBW_BUF_DEPTH) && !pop |=> !in_if.ready;
	endproperty
	a_buf_no_overrun: assert property (p_buf_no_overrun)
		else $error("buffer accepted a word while full");
endmodule

// [src/cbw_top.sv]
// bus bias state machine, local wake detection and driver/receiver gating
//
// Summary of operation
// - a rising or falling edge on the wake pin raises a local wake event.
// - local wake detection runs while the device sleeps.
// - wake pin edges are ignored in normal mode.
// - bias logic has four states: off, auto active, auto inactive, active.
// - battery supply falling low forces off: lines float, no bus load.
// - from off, battery supply rising ok moves to auto inactive.
// - low-power modes keep bias autonomous; auto inactive ties bus to ground.
// - remote wake pattern moves auto inactive to auto active, bus at 2.5 V.
// - controller must enter normal before bus idle timeout, else auto inactive.
// - leaving normal/silent: auto active if bus recently busy, else inactive.
// - link mode requested under core or io undervoltage gives auto active.
// - low-power mode and bus idle past timeout drops auto active to inactive.
// - normal or silent mode runs active bias at half core supply.
// - active entered only on normal request with core and io supplies ok.
// - transmit low before standby exit clamps driver until transmit goes high.
// - active to low-power after long bus silence goes auto inactive.
// - active to auto active on early low-power switch or supply undervoltage.
// - normal mode drives dominant on transmit low; receive follows the bus.
// - silent mode keeps driver off; receive still follows the bus.
// - standby receive output high, low while a wake event is pending.
// - sleep modes hold receive high, tri-stated without io or battery supply.
`timescale 1ns/1ps
`include "cbw_cfg.svh"
module cbw_top #(
	parameter logic [`CBW_SIL_W-1:0] SILENCE_US = `CBW_SILENCE_US_DEF
) (
	// clock and reset
	input  logic                clock_i,
	input  logic                reset_i,
	// operating mode from the mode sequencer
	input  cbw_pkg::cbw_mode_e  mode_i,
	// remote wake pattern seen by the low-power receiver
	input  logic                remote_bus_wake_pattern_i,
	// pins and comparators
	input  logic                wake_pin_i,
	input  logic                txd_i,
	input  logic                bus_dominant_i,
	input  logic                battery_supply_low_falling_i,
	input  logic                battery_supply_ok_rising_i,
	input  logic                core_supply_low_falling_i,
	input  logic                core_supply_ok_rising_i,
	input  logic                io_supply_low_falling_i,
	input  logic                io_supply_ok_rising_i,
	// bias controls
	output cbw_pkg::cbw_bias_e  bias_state_o,
	output logic                bus_float_o,
	output logic                bias_to_ground_o,
	output logic                bias_to_mid_o,
	output logic                bias_from_core_o,
	// driver and receiver
	output logic                drive_dominant_o,
	output logic                transmit_stuck_low_clamp_o,
	output logic                rxd_o,
	output logic                rxd_oe_n_o,
	output logic                low_power_rx_on_o,
	output logic                wake_detect_on_o,
	output logic                bus_idle_timeout_o,
	// wake records
	output logic                wake_valid_o,
	input  logic                wake_ready_i,
	output cbw_pkg::cbw_wake_s  wake_source_o
);
	function automatic logic is_low_power(input cbw_pkg::cbw_mode_e m);
		is_low_power = (m == cbw_pkg::MODE_STANDBY) ||
			(m == cbw_pkg::MODE_GOTOSLEEP) || (m == cbw_pkg::MODE_SLEEP);
	endfunction

	function automatic logic is_link(input cbw_pkg::cbw_mode_e m);
		is_link = (m == cbw_pkg::MODE_NORMAL) ||
			(m == cbw_pkg::MODE_SILENT);
	endfunction

	// two-flop synchronisers for everything that comes off-chip
	localparam logic [`CBW_SYNC_W-1:0] SYNC_RST = `CBW_SYNC_RST;
	logic [`CBW_SYNC_W-1:0] async_in;
	logic [`CBW_SYNC_W-1:0] meta_q;
	logic [`CBW_SYNC_W-1:0] sync_q;

	assign async_in[`CBW_S_WAKE]     = wake_pin_i;
	assign async_in[`CBW_S_TXD]      = txd_i;
	assign async_in[`CBW_S_BUSDOM]   = bus_dominant_i;
	assign async_in[`CBW_S_BATT_LOW] = battery_supply_low_falling_i;
	assign async_in[`CBW_S_BATT_OK]  = battery_supply_ok_rising_i;
	assign async_in[`CBW_S_CORE_LOW] = core_supply_low_falling_i;
	assign async_in[`CBW_S_CORE_OK]  = core_supply_ok_rising_i;
	assign async_in[`CBW_S_IO_LOW]   = io_supply_low_falling_i;
	assign async_in[`CBW_S_IO_OK]    = io_supply_ok_rising_i;

	genvar gi;
	generate
		for (gi = 0; gi < `CBW_SYNC_W; gi++) begin : g_sync
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					meta_q[gi] <= SYNC_RST[gi];
					sync_q[gi] <= SYNC_RST[gi];
				end else begin
					meta_q[gi] <= async_in[gi];
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	logic wake_s;
	logic txd_s;
	logic bus_dom_s;
	logic batt_low_s;
	logic batt_ok_s;
	logic core_low_s;
	logic core_ok_s;
	logic io_low_s;
	logic io_ok_s;
	assign wake_s     = sync_q[`CBW_S_WAKE];
	assign txd_s      = sync_q[`CBW_S_TXD];
	assign bus_dom_s  = sync_q[`CBW_S_BUSDOM];
	assign batt_low_s = sync_q[`CBW_S_BATT_LOW];
	assign batt_ok_s  = sync_q[`CBW_S_BATT_OK];
	assign core_low_s = sync_q[`CBW_S_CORE_LOW];
	assign core_ok_s  = sync_q[`CBW_S_CORE_OK];
	assign io_low_s   = sync_q[`CBW_S_IO_LOW];
	assign io_ok_s    = sync_q[`CBW_S_IO_OK];

	logic supply_uv;
	assign supply_uv = core_low_s | io_low_s;

	// microsecond tick keeps the idle counter narrow
	logic [`CBW_TICK_W-1:0] tick_cnt_q;
	logic                   tick;
	assign tick = (tick_cnt_q == `CBW_TICK_W'(`CBW_TICK_CYCLES - 1));

	always_ff @(posedge clock_i) begin
		if (reset_i || tick) begin
			tick_cnt_q <= `CBW_TICK_W'(0);
		end else begin
			tick_cnt_q <= tick_cnt_q + `CBW_TICK_W'(1);
		end
	end

	// bus idle timer
	logic                  bus_prev_q;
	logic                  bus_change;
	logic [`CBW_SIL_W-1:0] sil_cnt_q;
	logic                  expired;
	assign bus_change = bus_dom_s ^ bus_prev_q;
	assign expired    = (sil_cnt_q == SILENCE_US);

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			bus_prev_q <= 1'b0;
		end else begin
			bus_prev_q <= bus_dom_s;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			sil_cnt_q <= `CBW_SIL_W'(0);
		end else if (bus_change || remote_bus_wake_pattern_i) begin
			sil_cnt_q <= `CBW_SIL_W'(0);
		end else if (tick && !expired) begin
			sil_cnt_q <= sil_cnt_q + `CBW_SIL_W'(1);
		end
	end

	// bias state machine
	cbw_pkg::cbw_bias_e bias_q;
	cbw_pkg::cbw_bias_e bias_d;

	always_comb begin
		bias_d = bias_q;
		case (bias_q)
			cbw_pkg::BIAS_OFF: begin
				if (batt_ok_s) begin
					bias_d = cbw_pkg::BIAS_AUTO_INACTIVE;
				end
			end
			cbw_pkg::BIAS_AUTO_INACTIVE, cbw_pkg::BIAS_AUTO_ACTIVE: begin
				if (is_link(mode_i) && supply_uv) begin
					bias_d = cbw_pkg::BIAS_AUTO_ACTIVE;
				end else if (mode_i == cbw_pkg::MODE_NORMAL &&
						core_ok_s && io_ok_s) begin
					bias_d = cbw_pkg::BIAS_ACTIVE;
				end else if (bias_q == cbw_pkg::BIAS_AUTO_INACTIVE) begin
					if (remote_bus_wake_pattern_i) begin
						bias_d = cbw_pkg::BIAS_AUTO_ACTIVE;
					end
				end else if (is_low_power(mode_i) && expired) begin
					bias_d = cbw_pkg::BIAS_AUTO_INACTIVE;
				end
			end
			cbw_pkg::BIAS_ACTIVE: begin
				if (is_low_power(mode_i)) begin
					bias_d = expired ? cbw_pkg::BIAS_AUTO_INACTIVE
						: cbw_pkg::BIAS_AUTO_ACTIVE;
				end else if (supply_uv) begin
					bias_d = cbw_pkg::BIAS_AUTO_ACTIVE;
				end
			end
			default: begin
				bias_d = cbw_pkg::BIAS_OFF;
			end
		endcase
		if (batt_low_s) begin
			bias_d = cbw_pkg::BIAS_OFF;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			bias_q <= cbw_pkg::BIAS_OFF;
		end else begin
			bias_q <= bias_d;
		end
	end

	assign bias_state_o     = bias_q;
	assign bus_float_o      = (bias_q == cbw_pkg::BIAS_OFF);
	assign bias_to_ground_o = (bias_q == cbw_pkg::BIAS_AUTO_INACTIVE);
	assign bias_to_mid_o    = (bias_q == cbw_pkg::BIAS_AUTO_ACTIVE);
	assign bias_from_core_o = (bias_q == cbw_pkg::BIAS_ACTIVE);

	// pin history is meaningless until it has crossed both sync flops;
	// a pin strapped high would otherwise fake an edge after reset
	logic [`CBW_SETTLE_W-1:0] settle_q;
	logic                     wake_settled;
	assign wake_settled = (settle_q == `CBW_SETTLE_DONE);

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			settle_q <= `CBW_SETTLE_W'(0);
		end else if (!wake_settled) begin
			settle_q <= settle_q + `CBW_SETTLE_W'(1);
		end
	end

	// local wake: edge on the synced pin, gated off in link modes
	logic wake_prev_q;
	logic local_evt;
	assign wake_detect_on_o = !is_link(mode_i);
	assign local_evt = wake_detect_on_o && wake_settled &&
		(wake_s ^ wake_prev_q);

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			wake_prev_q <= 1'b0;
		end else begin
			// history tracks while disabled so re-enable gives no false edge
			wake_prev_q <= wake_s;
		end
	end

	// pending wake flag, cleared by normal mode; a new event wins
	logic wake_pend_q;
	logic any_evt;
	assign any_evt = local_evt | remote_bus_wake_pattern_i;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			wake_pend_q <= 1'b0;
		end else if (any_evt) begin
			wake_pend_q <= 1'b1;
		end else if (mode_i == cbw_pkg::MODE_NORMAL) begin
			wake_pend_q <= 1'b0;
		end
	end

	// wake records wait here while the buffer is full
	logic loc_rec_q;
	logic rem_rec_q;
	cbw_stream_if fill_if ();
	cbw_stream_if drain_if ();
	logic push;
	assign fill_if.valid = loc_rec_q | rem_rec_q;
	// one driver for the whole record: remote in bit 1, local in bit 0
	assign fill_if.data = {rem_rec_q, loc_rec_q};
	assign push = fill_if.valid & fill_if.ready;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			loc_rec_q <= 1'b0;
			rem_rec_q <= 1'b0;
		end else begin
			loc_rec_q <= local_evt | (loc_rec_q & ~push);
			rem_rec_q <= remote_bus_wake_pattern_i | (rem_rec_q & ~push);
		end
	end

	cbw_buf2 u_buf (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.in_if   (fill_if),
		.out_if  (drain_if)
	);

	assign wake_valid_o   = drain_if.valid;
	assign drain_if.ready = wake_ready_i;
	assign wake_source_o  = drain_if.data;

	// stuck-low transmit clamp
	logic txd_low_stby_q;
	logic clamp_q;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			txd_low_stby_q <= 1'b0;
		end else if (mode_i == cbw_pkg::MODE_STANDBY) begin
			txd_low_stby_q <= ~txd_s;
		end else if (bias_q == cbw_pkg::BIAS_ACTIVE) begin
			txd_low_stby_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			clamp_q <= 1'b0;
		end else if (bias_q != cbw_pkg::BIAS_ACTIVE) begin
			clamp_q <= (bias_d == cbw_pkg::BIAS_ACTIVE) & txd_low_stby_q;
		end else if (txd_s) begin
			clamp_q <= 1'b0;
		end
	end

	assign transmit_stuck_low_clamp_o = clamp_q;
	assign drive_dominant_o = (bias_q == cbw_pkg::BIAS_ACTIVE) &&
		(mode_i == cbw_pkg::MODE_NORMAL) && !txd_s && !clamp_q;

	// receive output
	logic rxd_q;
	logic rxd_oe_n_q;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			rxd_q      <= `CBW_RXD_IDLE;
			rxd_oe_n_q <= 1'b1;
		end else begin
			rxd_oe_n_q <= 1'b0;
			case (mode_i)
				cbw_pkg::MODE_NORMAL, cbw_pkg::MODE_SILENT: begin
					rxd_q <= ~bus_dom_s;
				end
				cbw_pkg::MODE_STANDBY: begin
					rxd_q <= ~wake_pend_q;
				end
				default: begin
					rxd_q      <= `CBW_RXD_IDLE;
					rxd_oe_n_q <= ~io_ok_s | ~batt_ok_s;
				end
			endcase
		end
	end

	assign rxd_o              = rxd_q;
	assign rxd_oe_n_o         = rxd_oe_n_q;
	assign low_power_rx_on_o  = is_low_power(mode_i);
	assign bus_idle_timeout_o = expired;

	property p_off_on_uv;
		@(posedge clock_i) disable iff (reset_i)
		batt_low_s |=> bias_q == cbw_pkg::BIAS_OFF && bus_float_o;
	endproperty
	a_off_on_uv: assert property (p_off_on_uv)
		else $error("battery low did not force bias off");

	property p_off_recover;
		@(posedge clock_i) disable iff (reset_i)
		bias_q == cbw_pkg::BIAS_OFF && batt_ok_s && !batt_low_s
		|=> bias_q == cbw_pkg::BIAS_AUTO_INACTIVE;
	endproperty
	a_off_recover: assert property (p_off_recover)
		else $error("off did not recover to auto inactive");

	property p_remote_wake;
		@(posedge clock_i) disable iff (reset_i)
		bias_q == cbw_pkg::BIAS_AUTO_INACTIVE && is_low_power(mode_i) &&
		remote_bus_wake_pattern_i && !batt_low_s
		|=> bias_q == cbw_pkg::BIAS_AUTO_ACTIVE ##1 rem_rec_q || wake_valid_o;
	endproperty
	a_remote_wake: assert property (p_remote_wake)
		else $error("remote wake did not raise bias");

	property p_wake_edge;
		@(posedge clock_i) disable iff (reset_i)
		!is_link(mode_i) && wake_settled && $changed(wake_s)
		|=> loc_rec_q && wake_pend_q;
	endproperty
	a_wake_edge: assert property (p_wake_edge)
		else $error("wake pin edge lost");

	property p_wake_off_normal;
		@(posedge clock_i) disable iff (reset_i)
		mode_i == cbw_pkg::MODE_NORMAL |-> !local_evt;
	endproperty
	a_wake_off_normal: assert property (p_wake_off_normal)
		else $error("wake detected in normal mode");

	property p_leave_active;
		@(posedge clock_i) disable iff (reset_i)
		bias_q == cbw_pkg::BIAS_ACTIVE && is_low_power(mode_i) && !batt_low_s
		|=> bias_q == ($past(expired) ? cbw_pkg::BIAS_AUTO_INACTIVE
			: cbw_pkg::BIAS_AUTO_ACTIVE);
	endproperty
	a_leave_active: assert property (p_leave_active)
		else $error("wrong bias after leaving link mode");

	property p_uv_active;
		@(posedge clock_i) disable iff (reset_i)
		bias_q == cbw_pkg::BIAS_ACTIVE && supply_uv && !batt_low_s &&
		!(is_low_power(mode_i) && expired)
		|=> bias_q == cbw_pkg::BIAS_AUTO_ACTIVE;
	endproperty
	a_uv_active: assert property (p_uv_active)
		else $error("undervoltage did not leave active bias");

	property p_drive;
		@(posedge clock_i) disable iff (reset_i)
		drive_dominant_o |-> mode_i == cbw_pkg::MODE_NORMAL && !txd_s &&
		bias_q == cbw_pkg::BIAS_ACTIVE && !clamp_q;
	endproperty
	a_drive: assert property (p_drive)
		else $error("driver on outside normal transmit low");

	property p_rxd_standby;
		@(posedge clock_i) disable iff (reset_i)
		mode_i == cbw_pkg::MODE_STANDBY |=> rxd_q == !$past(wake_pend_q);
	endproperty
	a_rxd_standby: assert property (p_rxd_standby)
		else $error("standby receive output wrong");

	property p_idle_restart;
		@(posedge clock_i) disable iff (reset_i)
		bus_change |=> sil_cnt_q == `CBW_SIL_W'(0) && !bus_idle_timeout_o;
	endproperty
	a_idle_restart: assert property (p_idle_restart)
		else $error("idle timer not restarted by bus change");
endmodule

// [tb/cbw_ctrl_bus_model.sv]
// controller and bus model facing the transceiver pins
`timescale 1ns/1ps
module cbw_ctrl_bus_model (
	// clock
	input  logic clock_i,
	// scenario commands
	input  logic hold_low_i,
	input  logic other_dom_i,
	// transceiver driver output
	input  logic drive_dominant_i,
	// pins
	output logic txd_o,
	output logic bus_dominant_o
);
	initial begin
		txd_o          = 1'b1;
		bus_dominant_o = 1'b0;
	end
	// controller releases transmit high unless told to hold it low;
	// pins move after the rising edge so falling-edge stimulus never races
	always @(posedge clock_i) begin
		txd_o <= !hold_low_i;
	end
	// wired-and bus: any dominant driver wins, released bus is recessive
	always @(posedge clock_i) begin
		bus_dominant_o <= drive_dominant_i | other_dom_i;
	end
endmodule

// [tb/test_cbw_top.sv]
// self-checking bench for the bias and wake control block
`timescale 1ns/1ps
module test_cbw_top;
	logic               clock_i = 1'b0;
	logic               reset_i = 1'b1;
	cbw_pkg::cbw_mode_e mode_i  = cbw_pkg::MODE_STANDBY;
	logic               remote_i = 1'b0;
	logic               wake_pin_i = 1'b0;
	logic               batt_low_i = 1'b1;
	logic               batt_ok_i  = 1'b0;
	logic               core_low_i = 1'b0;
	logic               core_ok_i  = 1'b1;
	logic               io_low_i   = 1'b0;
	logic               io_ok_i    = 1'b1;
	logic               ready_i    = 1'b1;
	logic               hold_low   = 1'b0;
	logic               other_dom  = 1'b0;
	logic               txd, bus_dom, drv, clamp, rxd, oe_n, valid;
	logic               gnd_b, mid_b, core_b, float_b, lp_rx, wk_on, tmo;
	cbw_pkg::cbw_bias_e bias;
	cbw_pkg::cbw_wake_s src;
	int                 fail_count  = 0;
	int                 checks_done = 0;

	always #12.5 clock_i = ~clock_i;

	cbw_top #(.SILENCE_US(16'h0005)) dut (
		.clock_i(clock_i), .reset_i(reset_i), .mode_i(mode_i),
		.remote_bus_wake_pattern_i(remote_i), .wake_pin_i(wake_pin_i),
		.txd_i(txd), .bus_dominant_i(bus_dom),
		.battery_supply_low_falling_i(batt_low_i),
		.battery_supply_ok_rising_i(batt_ok_i),
		.core_supply_low_falling_i(core_low_i),
		.core_supply_ok_rising_i(core_ok_i),
		.io_supply_low_falling_i(io_low_i), .io_supply_ok_rising_i(io_ok_i),
		.bias_state_o(bias), .bus_float_o(float_b),
		.bias_to_ground_o(gnd_b), .bias_to_mid_o(mid_b),
		.bias_from_core_o(core_b), .drive_dominant_o(drv),
		.transmit_stuck_low_clamp_o(clamp), .rxd_o(rxd),
		.rxd_oe_n_o(oe_n), .low_power_rx_on_o(lp_rx),
		.wake_detect_on_o(wk_on), .bus_idle_timeout_o(tmo),
		.wake_valid_o(valid), .wake_ready_i(ready_i),
		.wake_source_o(src)
	);

	cbw_ctrl_bus_model partner (
		.clock_i(clock_i), .hold_low_i(hold_low), .other_dom_i(other_dom),
		.drive_dominant_i(drv), .txd_o(txd), .bus_dominant_o(bus_dom)
	);

	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask

	task chk(input string name, input logic [3:0] exp, input logic [3:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: pick = drv;
			1: pick = rxd;
			2: pick = valid;
			3: pick = clamp;
			default: pick = oe_n;
		endcase
	endfunction

	// bounded waits; running out counts and ends the run
	task wait_bias(input cbw_pkg::cbw_bias_e exp, input int n);
		int i;
		for (i = 0; i < n && bias !== exp; i++) cyc(1);
		chk("bias_state", exp, bias);
		if (bias !== exp) finish_test();
	endtask

	task wait_on(input string name, input int sel, input logic v, input int n);
		int i;
		for (i = 0; i < n && pick(sel) !== v; i++) cyc(1);
		chk(name, v, pick(sel));
		if (pick(sel) !== v) finish_test();
	endtask

	task t_reset;
		chk("bias_state", cbw_pkg::BIAS_OFF, bias);
		chk("bus_float", 1'b1, float_b);
		chk("rxd", 1'b1, rxd);
		chk("wake_valid", 1'b0, valid);
	endtask

	task t_power_up;
		batt_low_i = 1'b0;
		batt_ok_i  = 1'b1;
		wait_bias(cbw_pkg::BIAS_AUTO_INACTIVE, 8);
		chk("bias_to_ground", 1'b1, gnd_b);
		chk("low_power_rx", 1'b1, lp_rx);
	endtask

	task t_remote_wake;
		remote_i = 1'b1;
		cyc(1);
		remote_i = 1'b0;
		wait_bias(cbw_pkg::BIAS_AUTO_ACTIVE, 4);
		chk("bias_to_mid", 1'b1, mid_b);
		cyc(150);
		chk("bias_state", cbw_pkg::BIAS_AUTO_ACTIVE, bias);
		wait_bias(cbw_pkg::BIAS_AUTO_INACTIVE, 100);
		wait_on("wake_valid", 2, 1'b0, 8);
	endtask

	task t_normal_silent;
		mode_i = cbw_pkg::MODE_NORMAL;
		wait_bias(cbw_pkg::BIAS_ACTIVE, 4);
		chk("bias_from_core", 1'b1, core_b);
		hold_low = 1'b1;
		wait_on("drive_dominant", 0, 1'b1, 6);
		wait_on("rxd", 1, 1'b0, 6);
		hold_low = 1'b0;
		wait_on("rxd", 1, 1'b1, 8);
		mode_i   = cbw_pkg::MODE_SILENT;
		hold_low = 1'b1;
		cyc(6);
		chk("drive_dominant", 1'b0, drv);
		chk("bias_state", cbw_pkg::BIAS_ACTIVE, bias);
		other_dom = 1'b1;
		wait_on("rxd", 1, 1'b0, 6);
		other_dom = 1'b0;
		hold_low  = 1'b0;
		cyc(6);
	endtask

	task t_leave;
		// bus just went recessive, so the timer is fresh
		mode_i = cbw_pkg::MODE_STANDBY;
		wait_bias(cbw_pkg::BIAS_AUTO_ACTIVE, 4);
		wait_bias(cbw_pkg::BIAS_AUTO_INACTIVE, 260);
		mode_i = cbw_pkg::MODE_NORMAL;
		wait_bias(cbw_pkg::BIAS_ACTIVE, 4);
		cyc(250);
		chk("idle_timeout", 1'b1, tmo);
		mode_i = cbw_pkg::MODE_SLEEP;
		wait_bias(cbw_pkg::BIAS_AUTO_INACTIVE, 4);
	endtask

	task t_wake_pin;
		ready_i = 1'b0;
		chk("wake_detect_on", 1'b1, wk_on);
		wake_pin_i = 1'b1;
		wait_on("wake_valid", 2, 1'b1, 8);
		chk("wake_source", 2'b01, src);
		cyc(5);
		chk("wake_valid", 1'b1, valid);
		ready_i = 1'b1;
		wait_on("wake_valid", 2, 1'b0, 4);
		wake_pin_i = 1'b0;
		wait_on("wake_valid", 2, 1'b1, 8);
		chk("wake_source", 2'b01, src);
		mode_i = cbw_pkg::MODE_STANDBY;
		wait_on("rxd", 1, 1'b0, 4);
		mode_i = cbw_pkg::MODE_NORMAL;
		cyc(4);
		chk("wake_detect_on", 1'b0, wk_on);
		wait_on("wake_valid", 2, 1'b0, 4);
		wake_pin_i = 1'b1;
		cyc(10);
		chk("wake_valid", 1'b0, valid);
		mode_i = cbw_pkg::MODE_STANDBY;
		cyc(4);
		chk("rxd", 1'b1, rxd);
	endtask

	task t_clamp;
		hold_low = 1'b1;
		cyc(6);
		mode_i = cbw_pkg::MODE_NORMAL;
		wait_bias(cbw_pkg::BIAS_ACTIVE, 4);
		cyc(1);
		chk("clamp", 1'b1, clamp);
		chk("drive_dominant", 1'b0, drv);
		hold_low = 1'b0;
		wait_on("clamp", 3, 1'b0, 8);
		hold_low = 1'b1;
		wait_on("drive_dominant", 0, 1'b1, 6);
		hold_low = 1'b0;
		cyc(6);
	endtask

	task t_supply;
		core_low_i = 1'b1;
		core_ok_i  = 1'b0;
		wait_bias(cbw_pkg::BIAS_AUTO_ACTIVE, 6);
		mode_i = cbw_pkg::MODE_STANDBY;
		wait_bias(cbw_pkg::BIAS_AUTO_INACTIVE, 260);
		mode_i = cbw_pkg::MODE_NORMAL;
		wait_bias(cbw_pkg::BIAS_AUTO_ACTIVE, 4);
		core_low_i = 1'b0;
		core_ok_i  = 1'b1;
		mode_i     = cbw_pkg::MODE_GOTOSLEEP;
		cyc(4);
		chk("low_power_rx", 1'b1, lp_rx);
		chk("rxd", 1'b1, rxd);
		chk("rxd_oe_n", 1'b0, oe_n);
		io_low_i = 1'b1;
		io_ok_i  = 1'b0;
		wait_on("rxd_oe_n", 4, 1'b1, 6);
		batt_low_i = 1'b1;
		batt_ok_i  = 1'b0;
		wait_bias(cbw_pkg::BIAS_OFF, 6);
		chk("bus_float", 1'b1, float_b);
	endtask

	initial begin
		cyc(10);
		reset_i = 1'b0;
		cyc(1);
		t_reset();
		t_power_up();
		t_remote_wake();
		t_normal_silent();
		t_leave();
		t_wake_pin();
		t_clamp();
		t_supply();
		finish_test();
	end
endmodule
